// File: logic/rrc_top.sv
// reference and regulator control registers with bus supply detection
// Functional notes
// - gain bit 7: 0 gives 2x, 1 gives 1x
// - bits 6:5 read zero, writes ignored
// - override bit 4 forces regulator reference
// - bit 3 selects pin or supply reference
// - bit 2 switches temperature sensor
// - bit 1 switches bias generator
// - bit 0 drives reference buffer onto pin
// - software can disable supply regulator
// - supply regulator low-power suspend mode select
// - status bit shows current bus supply level
// - interrupt on every bus supply edge
// - interrupt is edge pulse, no pending flag
// - bus reset source resets on any edge
// - core regulator stays on in stop by default
// - shutdown bit powers core off in stop
// - core regulator low-power bit selects suspend mode
// - supply disable bit 7: 1 disables
// - bus power status at bit 6
// - supply low-power bit 4: 1 low power
`timescale 1ns/1ps
`include "rrc_regs.svh"
module rrc_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_we,
  input wire logic sfr_re,
  output logic [7:0] sfr_rdata,
  input wire logic vbus_in,
  input wire logic vbus_int_enable,
  input wire logic vbus_reset_enable,
  input wire logic stop_mode,
  output logic vbus_irq,
  output logic vbus_reset_req,
  output rrc_pkg::rrc_analog_t analog_ctrl,
  output rrc_pkg::rrc_power_t power_ctrl
);
  logic [7:0] ref_ctrl_r;
  logic [7:0] reg_ctrl_r;
  logic [7:0] rdata_r;
  logic vbus_level;
  logic vbus_edge;
  logic irq_r;
  logic rst_req_r;

  // ----------------------------------------------------------------
  // bus supply synchroniser
  // ----------------------------------------------------------------
  rrc_vbus_sync u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .vbus_in(vbus_in),
    .level(vbus_level),
    .edge_pulse(vbus_edge)
  );

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  // masking at the write keeps reference bits 6:5 at zero, so the read path
  // needs no special case for them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ref_ctrl_r <= `RRC_REF_RESET;
    end else if (sfr_we && hit(sfr_addr, `RRC_REF_CTRL_ADDR)) begin
      ref_ctrl_r <= sfr_wdata & `RRC_REF_WMASK;
    end
  end

  // status bit 6 is never stored; it is read live from the synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_ctrl_r <= `RRC_REG_RESET;
    end else if (sfr_we && hit(sfr_addr, `RRC_REG_CTRL_ADDR)) begin
      reg_ctrl_r <= sfr_wdata & `RRC_REG_WMASK;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // a write and a read in one cycle return the old value, because the
  // read samples the register before the write lands
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= 8'h00;
    end else if (sfr_re) begin
      if (hit(sfr_addr, `RRC_REF_CTRL_ADDR)) begin
        rdata_r <= ref_ctrl_r;
      end else if (hit(sfr_addr, `RRC_REG_CTRL_ADDR)) begin
        rdata_r <= reg_ctrl_r;
        rdata_r[`RRC_REG_VBUS_BIT] <= vbus_level;
      end else begin
        rdata_r <= 8'h00;
      end
    end
  end
  assign sfr_rdata = rdata_r;

  // ----------------------------------------------------------------
  // bus supply events
  // ----------------------------------------------------------------
  // one-cycle pulses; the interrupt controller latches them, so there
  // is no flag here for software to clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= vbus_edge && vbus_int_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rst_req_r <= 1'b0;
    end else begin
      rst_req_r <= vbus_edge && vbus_reset_enable;
    end
  end
  assign vbus_irq = irq_r;
  assign vbus_reset_req = rst_req_r;

  // ----------------------------------------------------------------
  // analog and power controls
  // ----------------------------------------------------------------
  always_comb begin
    analog_ctrl.gain_1x = ref_ctrl_r[`RRC_REF_GAIN_BIT];
    if (ref_ctrl_r[`RRC_REF_OVR_BIT]) begin
      analog_ctrl.src = rrc_pkg::RRC_SRC_REG;
    end else if (ref_ctrl_r[`RRC_REF_SEL_BIT]) begin
      analog_ctrl.src = rrc_pkg::RRC_SRC_VDD;
    end else begin
      analog_ctrl.src = rrc_pkg::RRC_SRC_PIN;
    end
    analog_ctrl.temp_on = ref_ctrl_r[`RRC_REF_TEMP_BIT];
    analog_ctrl.bias_on = ref_ctrl_r[`RRC_REF_BIAS_BIT];
    analog_ctrl.buf_on = ref_ctrl_r[`RRC_REF_BUF_BIT];
  end

  // the low-power core mode is not blocked in hardware; software must
  // avoid it while awake or with the supply regulator off
  always_comb begin
    power_ctrl.supply_reg_on = !reg_ctrl_r[`RRC_REG_DIS_BIT];
    power_ctrl.supply_reg_low_power = reg_ctrl_r[`RRC_REG_SLP_BIT];
    power_ctrl.core_reg_on = !(stop_mode && reg_ctrl_r[`RRC_REG_STOP_BIT]);
    power_ctrl.core_reg_low_power = reg_ctrl_r[`RRC_REG_CLP_BIT];
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // the reset, write and read checks lean on the bus and the pins rather than the stored bits, so
  // a slip in the register logic shows up instead of being copied here
  reset_values_a: assert property (
    $past(sys_rst) |-> analog_ctrl.src == rrc_pkg::RRC_SRC_PIN
    && power_ctrl.supply_reg_on && !power_ctrl.core_reg_low_power
    && sfr_rdata == 8'h00)
    else $error("outputs not at reset values");

  // ----------------------------------------------------------------
  // reference register checks
  // ----------------------------------------------------------------

  unused_read_zero_a: assert property (
    sfr_re && hit(sfr_addr, `RRC_REF_CTRL_ADDR) |=> sfr_rdata[6:5] == 2'b00)
    else $error("unused reference bits read nonzero");

  ref_write_a: assert property (
    sfr_we && hit(sfr_addr, `RRC_REF_CTRL_ADDR)
    |=> analog_ctrl.gain_1x == $past(sfr_wdata[`RRC_REF_GAIN_BIT]))
    else $error("gain select did not follow write");

  override_src_a: assert property (
    ref_ctrl_r[`RRC_REF_OVR_BIT] |-> analog_ctrl.src == rrc_pkg::RRC_SRC_REG)
    else $error("override did not select regulator");

  select_src_a: assert property (
    !ref_ctrl_r[`RRC_REF_OVR_BIT] |-> analog_ctrl.src ==
    (ref_ctrl_r[`RRC_REF_SEL_BIT] ? rrc_pkg::RRC_SRC_VDD
                                   : rrc_pkg::RRC_SRC_PIN))
    else $error("reference select wrong");

  temp_write_a: assert property (
    sfr_we && hit(sfr_addr, `RRC_REF_CTRL_ADDR)
    |=> analog_ctrl.temp_on == $past(sfr_wdata[`RRC_REF_TEMP_BIT]))
    else $error("temperature sensor enable did not follow write");

  bias_write_a: assert property (
    sfr_we && hit(sfr_addr, `RRC_REF_CTRL_ADDR)
    |=> analog_ctrl.bias_on == $past(sfr_wdata[`RRC_REF_BIAS_BIT]))
    else $error("bias enable did not follow write");

  buf_write_a: assert property (
    sfr_we && hit(sfr_addr, `RRC_REF_CTRL_ADDR)
    |=> analog_ctrl.buf_on == $past(sfr_wdata[`RRC_REF_BUF_BIT]))
    else $error("buffer enable did not follow write");

  ref_read_a: assert property (
    sfr_re && hit(sfr_addr, `RRC_REF_CTRL_ADDR)
    |=> sfr_rdata[`RRC_REF_GAIN_BIT] == $past(analog_ctrl.gain_1x))
    else $error("gain select read back wrong");

  ref_hold_a: assert property (
    !(sfr_we && hit(sfr_addr, `RRC_REF_CTRL_ADDR)) |=> $stable(analog_ctrl))
    else $error("reference controls moved without a write");

  src_onehot_a: assert property (
    $onehot(analog_ctrl.src))
    else $error("reference source not one-hot");

  // ----------------------------------------------------------------
  // bus supply checks
  // ----------------------------------------------------------------
  // a pin change reaches the event outputs three edges later

  vbus_status_a: assert property (
    sfr_re && hit(sfr_addr, `RRC_REG_CTRL_ADDR) && $stable(vbus_in)
    && vbus_in == $past(vbus_in, 2)
    |=> sfr_rdata[`RRC_REG_VBUS_BIT] == $past(vbus_in))
    else $error("bus power status stale");

  vbus_irq_a: assert property (
    $changed(vbus_in) ##2 vbus_int_enable |=> vbus_irq)
    else $error("bus supply edge gave no interrupt");

  irq_pulse_a: assert property (
    !$past(vbus_edge) |-> !vbus_irq)
    else $error("interrupt outlived its edge");

  irq_enable_a: assert property (
    vbus_irq |-> $past(vbus_int_enable))
    else $error("interrupt while disabled");

  vbus_reset_a: assert property (
    vbus_reset_req |-> $past(vbus_reset_enable) && $past(vbus_edge))
    else $error("reset request without edge");

  reset_edge_a: assert property (
    $changed(vbus_in) ##2 vbus_reset_enable |=> vbus_reset_req)
    else $error("bus supply edge gave no reset request");

  // ----------------------------------------------------------------
  // power checks
  // ----------------------------------------------------------------

  stop_core_a: assert property (
    stop_mode && !reg_ctrl_r[`RRC_REG_STOP_BIT] |-> power_ctrl.core_reg_on)
    else $error("core regulator off in stop by default");

  stop_shut_a: assert property (
    stop_mode && reg_ctrl_r[`RRC_REG_STOP_BIT] |-> !power_ctrl.core_reg_on)
    else $error("core regulator not shut in stop");

  supply_dis_a: assert property (
    sfr_we && hit(sfr_addr, `RRC_REG_CTRL_ADDR) && sfr_wdata[7]
    |=> !power_ctrl.supply_reg_on)
    else $error("supply regulator not disabled");

  supply_en_a: assert property (
    sfr_we && hit(sfr_addr, `RRC_REG_CTRL_ADDR)
    && !sfr_wdata[`RRC_REG_DIS_BIT] |=> power_ctrl.supply_reg_on)
    else $error("supply regulator not enabled");

  supply_lp_a: assert property (
    sfr_we && hit(sfr_addr, `RRC_REG_CTRL_ADDR)
    |=> power_ctrl.supply_reg_low_power == $past(sfr_wdata[`RRC_REG_SLP_BIT]))
    else $error("supply low-power mode did not follow write");

  core_lp_a: assert property (
    sfr_we && hit(sfr_addr, `RRC_REG_CTRL_ADDR)
    |=> power_ctrl.core_reg_low_power == $past(sfr_wdata[`RRC_REG_CLP_BIT]))
    else $error("core low-power mode did not follow write");

  reg_read_a: assert property (
    sfr_re && hit(sfr_addr, `RRC_REG_CTRL_ADDR)
    |=> sfr_rdata[`RRC_REG_DIS_BIT] == !$past(power_ctrl.supply_reg_on))
    else $error("supply disable read back wrong");

  reg_hold_a: assert property (
    !(sfr_we && hit(sfr_addr, `RRC_REG_CTRL_ADDR)) |=> $stable(reg_ctrl_r))
    else $error("regulator controls moved without a write");

  // ----------------------------------------------------------------
  // cover properties
  // ----------------------------------------------------------------

  cov_irq_c: cover property (vbus_irq);
  cov_status_c: cover property (sfr_re && vbus_level);
  cov_reset_c: cover property (vbus_reset_req);
  cov_override_c: cover property (analog_ctrl.src == rrc_pkg::RRC_SRC_REG);
  cov_stop_c: cover property (stop_mode && !power_ctrl.core_reg_on);
endmodule : rrc_top

// File: logic/rrc_regs.svh
// register map and field constants for the reference/regulator control block
`ifndef RRC_REGS_SVH
`define RRC_REGS_SVH
`define RRC_REF_CTRL_ADDR 8'hd1
`define RRC_REG_CTRL_ADDR 8'hc9
`define RRC_REF_RESET 8'h00
`define RRC_REG_RESET 8'h00
`define RRC_REF_WMASK 8'h9f
`define RRC_REG_WMASK 8'hbf
`define RRC_REF_GAIN_BIT 7
`define RRC_REF_OVR_BIT 4
`define RRC_REF_SEL_BIT 3
`define RRC_REF_TEMP_BIT 2
`define RRC_REF_BIAS_BIT 1
`define RRC_REF_BUF_BIT 0
`define RRC_REG_DIS_BIT 7
`define RRC_REG_VBUS_BIT 6
`define RRC_REG_SLP_BIT 4
`define RRC_REG_STOP_BIT 3
`define RRC_REG_CLP_BIT 1
`endif

// File: logic/rrc_pkg.sv
// types shared by the reference/regulator control block
package rrc_pkg;
  typedef enum logic [2:0] {
    RRC_SRC_PIN = 3'h1,
    RRC_SRC_VDD = 3'h2,
    RRC_SRC_REG = 3'h4
  } rrc_ref_src_t;

  typedef struct packed {
    logic gain_1x;
    rrc_ref_src_t src;
    logic temp_on;
    logic bias_on;
    logic buf_on;
  } rrc_analog_t;

  typedef struct packed {
    logic supply_reg_on;
    logic supply_reg_low_power;
    logic core_reg_on;
    logic core_reg_low_power;
  } rrc_power_t;
endpackage : rrc_pkg

// File: logic/rrc_vbus_sync.sv
// bus supply detect synchroniser and edge detector
`timescale 1ns/1ps
module rrc_vbus_sync (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic vbus_in,
  output logic level,
  output logic edge_pulse
);
  logic meta_r;
  logic sync_r;
  logic prev_r;

  // meta_r is read only by sync_r; the pin is synchronous to clk, so in
  // reset every stage takes the pin level and the chain agrees with it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_r <= vbus_in;
      sync_r <= vbus_in;
    end else begin
      meta_r <= vbus_in;
      sync_r <= meta_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_r <= vbus_in;
    end else begin
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  // a bus supply already present at reset gives no edge after release
  assign edge_pulse = sync_r ^ prev_r;
endmodule : rrc_vbus_sync

// File: verif/test_reference_regulator_control.sv
// self-checking bench for the reference/regulator control block
`timescale 1ns/1ps
module test_reference_regulator_control;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_we = 1'b0;
  logic sfr_re = 1'b0;
  logic [7:0] sfr_rdata;
  logic vbus_in = 1'b0;
  logic irq_en = 1'b0;
  logic rst_en = 1'b0;
  logic stop_mode = 1'b0;
  logic vbus_irq;
  logic vbus_reset_req;
  rrc_pkg::rrc_analog_t analog_ctrl;
  rrc_pkg::rrc_power_t power_ctrl;
  int failures = 0;
  int tests_run = 0;
  int irq_hi = 0;
  int rst_hi = 0;
  // ref write value and resulting analog controls, packed as the struct
  logic [7:0] ref_v [4] = '{8'h00, 8'h08, 8'h18, 8'h87};
  logic [7:0] ana_v [4] = '{8'h08, 8'h10, 8'h20, 8'h4f};
  // regulator write value, stop level and resulting power controls
  logic [7:0] reg_v [6] = '{8'h00, 8'h80, 8'h10, 8'h02, 8'h08, 8'h08};
  logic stp_v [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0] pwr_v [6] = '{8'h0a, 8'h02, 8'h0e, 8'h0b, 8'h0a, 8'h08};

  rrc_top DUT (
    .clk(clk),
    .sys_rst(sys_rst),
    .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata),
    .sfr_we(sfr_we),
    .sfr_re(sfr_re),
    .sfr_rdata(sfr_rdata),
    .vbus_in(vbus_in),
    .vbus_int_enable(irq_en),
    .vbus_reset_enable(rst_en),
    .stop_mode(stop_mode),
    .vbus_irq(vbus_irq),
    .vbus_reset_req(vbus_reset_req),
    .analog_ctrl(analog_ctrl),
    .power_ctrl(power_ctrl)
  );

  initial begin
    forever #2.5 clk = ~clk;
  end

  // counting high cycles also catches pulses wider than one cycle
  always @(negedge clk) begin
    if (vbus_irq === 1'b1) irq_hi++;
    if (vbus_reset_req === 1'b1) rst_hi++;
  end

  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_we = 1'b1;
    @(negedge clk);
    sfr_we = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_re = 1'b1;
    @(negedge clk);
    sfr_re = 1'b0;
    chk(sfr_rdata, exp);
    @(negedge clk);
  endtask : rd

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  initial begin
    #50000;
    failures++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    rd(8'hd1, 8'h00);
    rd(8'hc9, 8'h00);
    chk({1'b0, analog_ctrl}, 8'h08);
    chk({4'h0, power_ctrl}, 8'h0a);
    for (int i = 0; i < 4; i++) begin
      wr(8'hd1, ref_v[i]);
      chk({1'b0, analog_ctrl}, ana_v[i]);
      rd(8'hd1, ref_v[i]);
    end
    wr(8'hd1, 8'hff);
    chk({1'b0, analog_ctrl}, 8'h67);
    rd(8'hd1, 8'h9f);
    // unmapped write must leave the map untouched, unmapped read gives 0
    wr(8'hd0, 8'h00);
    rd(8'hd1, 8'h9f);
    rd(8'h00, 8'h00);
    for (int i = 0; i < 6; i++) begin
      stop_mode = stp_v[i];
      wr(8'hc9, reg_v[i]);
      if (reg_v[i][1]) repeat (12) @(negedge clk);
      chk({4'h0, power_ctrl}, pwr_v[i]);
      rd(8'hc9, reg_v[i]);
    end
    stop_mode = 1'b0;
    // writing 0xfd leaves core low-power bit 1 clear while the supply regulator is off
    wr(8'hc9, 8'hfd);
    chk({4'h0, power_ctrl}, 8'h06);
    rd(8'hc9, 8'hbd);
    irq_en = 1'b1;
    vbus_in = 1'b1;
    repeat (6) @(negedge clk);
    rd(8'hc9, 8'hfd);
    vbus_in = 1'b0;
    repeat (6) @(negedge clk);
    rd(8'hc9, 8'hbd);
    chk(8'(irq_hi), 8'h02);
    chk(8'(rst_hi), 8'h00);
    irq_en = 1'b0;
    rst_en = 1'b1;
    vbus_in = 1'b1;
    repeat (6) @(negedge clk);
    vbus_in = 1'b0;
    repeat (6) @(negedge clk);
    chk(8'(irq_hi), 8'h02);
    chk(8'(rst_hi), 8'h02);
    wrap_up();
  end
endmodule : test_reference_regulator_control
